// ==== rtl/twsi_slave.sv ====
// Purpose: Slave-only two-wire serial interface with register port
// Assumes: Bus lines are asynchronous; sampled by i_clk at 250 MHz
// Notes:   Open-drain pins as input, output-low and enable triples
//
// Functional notes
// - Ninth-clock ack low clears rx ack flag
// - Keep sending while acked; else release data
// - Eighth bit after start is direction
// - Drive tx ack control bit on ninth clock
// - Transmit when mode bit one, else receive
// - Busy set on start, cleared on stop
// - Address match flag follows comparison
// - Done flag low shifting, high plus interrupt
// - Own address from bits one to seven
// - First seven bits are address, MSB first
// - Address match raises the same interrupt
// - Ack low after matching address byte
// - Hold clock low until data access
// - Start: data falls while clock high
// - Never generate start; slave only
// - Bytes are eight bits, MSB first
// - Receiver acks; unacked transmitter releases data
// - Slave mode only when mode select is 110
// - Optional debounce of zero, one or two clocks
// - Disable releases both lines, stops activity
//
// Added by the designer: the register addresses and strobed register access.
`default_nettype none
module twsi_slave #(
  parameter int unsigned DEBOUNCE = 0
) (
  // Clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  // Register port
  input  wire logic [twsi_pkg::TWSI_AW-1:0] i_addr,
  input  wire logic [twsi_pkg::TWSI_DW-1:0] i_wdata,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  output logic      [twsi_pkg::TWSI_DW-1:0] o_rdata,
  // Interrupt request, gated by the enable
  input  wire logic                         i_irq_en,
  output logic                              o_irq,
  // Bus clock pin
  input  wire logic                         i_scl,
  output logic                              o_scl,
  output logic                              o_scl_oe,
  // Bus data pin
  input  wire logic                         i_sda,
  output logic                              o_sda,
  output logic                              o_sda_oe
);
  import twsi_pkg::*;

  // Filter history is three samples deep, so two clocks is the limit
  if (DEBOUNCE > 2) begin : g_bad_debounce
    $error("DEBOUNCE must be 0, 1 or 2");
  end

  // Registers
  logic [7:0]  ctrl0_r;
  logic [7:0]  own_r;
  logic [7:0]  data_r;
  logic [7:0]  shift_r;
  logic [3:0]  cnt_r;
  // Status flags, one per status bit except bit one, which reads zero
  logic        rx_ack_flag_r;   // Master ack level after a sent byte; set when not acked
  logic        srw_r;    // Direction bit of the last address
  logic        tx_ack_ctrl_r;   // Ack level to drive after a received byte
  logic        txm_r;    // Transmit when set, receive when clear
  logic        bb_r;     // Bus busy between start and stop
  logic        am_r;     // Own address matched
  logic        done_r;   // Byte finished
  logic        irq_r;
  logic        hold_r;
  logic        sda_lo_r;
  logic [7:0]  rdata_r;
  twsi_state_t st_r;
  // Synchronisers and debounce history
  logic [1:0]  scl_sy_r, sda_sy_r;
  logic [2:0]  scl_h_r, sda_h_r;
  logic        scl_f_r, sda_f_r;

  // Two-stage synchroniser, second stage feeds the filter only
  always_ff @(posedge i_clk) begin
    scl_sy_r <= {scl_sy_r[0], i_scl};
    sda_sy_r <= {sda_sy_r[0], i_sda};
  end

  // Filter stability terms; a glitch shorter than the window is dropped
  wire [2:0] win_mask   = 3'((1 << (DEBOUNCE + 1)) - 1);
  wire       scl_stable = ((scl_h_r & win_mask) == 3'h0) || ((scl_h_r & win_mask) == win_mask);
  wire       sda_stable = ((sda_h_r & win_mask) == 3'h0) || ((sda_h_r & win_mask) == win_mask);
  wire       scl_in     = scl_stable ? scl_h_r[0] : scl_f_r;
  wire       sda_in     = sda_stable ? sda_h_r[0] : sda_f_r;

  // Debounce window: level must agree for DEBOUNCE+1 samples
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scl_h_r <= 3'h7;
      sda_h_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      scl_h_r <= {scl_h_r[1:0], scl_sy_r[1]};
      sda_h_r <= {sda_h_r[1:0], sda_sy_r[1]};
      if (scl_stable) scl_f_r <= scl_h_r[0];
      if (sda_stable) sda_f_r <= sda_h_r[0];
    end
  end

  // Edge and condition detection against the previous filtered level
  wire enabled  = ctrl0_r[TWSI_B_EN] &&
                  (ctrl0_r[TWSI_B_MODE_L+2:TWSI_B_MODE_L] == TWSI_MODE_TWI);
  wire scl_rise = enabled && scl_in && !scl_f_r;
  wire scl_fall = enabled && !scl_in && scl_f_r;
  wire start_c  = enabled && scl_in && scl_f_r && sda_f_r && !sda_in;
  wire stop_c   = enabled && scl_in && scl_f_r && !sda_f_r && sda_in;

  // Register port decode
  wire wr_ctrl0 = i_wr && (i_addr == TWSI_OFS_CTRL0);
  wire wr_stat  = i_wr && (i_addr == TWSI_OFS_STAT);
  wire wr_own   = i_wr && (i_addr == TWSI_OFS_ADDR);
  wire wr_data  = i_wr && (i_addr == TWSI_OFS_DATA);
  wire rd_data  = i_rd && (i_addr == TWSI_OFS_DATA);
  wire release_hold = wr_data || rd_data;
  wire addr_hit = (shift_r[7:1] == own_r[7:1]);
  wire [7:0] stat_v = {done_r, am_r, bb_r, txm_r, tx_ack_ctrl_r, srw_r, 1'b0, rx_ack_flag_r};

  // Read mux
  wire [7:0] rd_mux = (i_addr == TWSI_OFS_CTRL0) ? ctrl0_r :
                      (i_addr == TWSI_OFS_STAT)  ? stat_v  :
                      (i_addr == TWSI_OFS_ADDR)  ? own_r   : data_r;

  // Software-owned control and address registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl0_r <= TWSI_RST_CTRL0;
      own_r   <= TWSI_RST_ADDR;
      tx_ack_ctrl_r  <= 1'b0;
      txm_r   <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      if (wr_ctrl0) ctrl0_r <= i_wdata;
      if (wr_own) own_r <= i_wdata;
      if (wr_stat) tx_ack_ctrl_r <= i_wdata[TWSI_B_TX_ACK_CTRL];
      if (wr_stat) txm_r <= i_wdata[TWSI_B_TXM];
      rdata_r <= i_rd ? rd_mux : 8'h00;
    end
  end

  // Bus state machine; the device only answers, never starts a frame
  always_ff @(posedge i_clk) begin
    if (i_rst || !enabled) begin
      st_r     <= TWSI_IDLE;
      shift_r  <= 8'h00;
      cnt_r    <= 4'h0;
      sda_lo_r <= 1'b0;
      hold_r   <= 1'b0;
      bb_r     <= 1'b0;
      am_r     <= 1'b0;
      done_r   <= 1'b0;
      srw_r    <= 1'b0;
      rx_ack_flag_r   <= 1'b0;
      irq_r    <= 1'b0;
      data_r   <= TWSI_RST_DATA;
    end else begin
      irq_r <= 1'b0;
      if (wr_data && !hold_r && st_r != TWSI_IDLE && st_r != TWSI_HOLD) begin
        data_r <= data_r; // Writes during a shift are ignored
      end else if (wr_data) begin
        data_r <= i_wdata;
      end
      if (release_hold && hold_r) begin
        hold_r <= 1'b0;
        if (txm_r) begin
          shift_r  <= wr_data ? i_wdata : data_r;
          st_r     <= TWSI_TX;
          cnt_r    <= 4'h0;
          done_r   <= 1'b0;
          sda_lo_r <= !(wr_data ? i_wdata[7] : data_r[7]);
        end else begin
          st_r   <= TWSI_RX;
          cnt_r  <= 4'h0;
          done_r <= 1'b0;
        end
      end
      if (start_c) begin
        bb_r     <= 1'b1;
        st_r     <= TWSI_ADDR;
        cnt_r    <= 4'h0;
        am_r     <= 1'b0;
        hold_r   <= 1'b0;
        sda_lo_r <= 1'b0;
      end else if (stop_c) begin
        bb_r     <= 1'b0;
        st_r     <= TWSI_IDLE;
        hold_r   <= 1'b0;
        sda_lo_r <= 1'b0;
      end else begin
        unique case (st_r)
          TWSI_IDLE, TWSI_HOLD: begin
          end
          TWSI_ADDR: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_in};
              cnt_r   <= cnt_r + 4'h1;
            end
            if (scl_fall && cnt_r == TWSI_BITS_BYTE) begin
              srw_r <= shift_r[0];
              if (addr_hit) begin
                am_r     <= 1'b1;
                irq_r    <= 1'b1;
                sda_lo_r <= 1'b1;
                st_r     <= TWSI_AACK;
              end else begin
                am_r <= 1'b0;
                st_r <= TWSI_IDLE;
              end
            end
          end
          TWSI_AACK, TWSI_RACK, TWSI_TACK: begin
            if (scl_rise && st_r == TWSI_TACK) begin
              rx_ack_flag_r <= sda_in;
            end
            if (scl_fall) begin
              sda_lo_r <= 1'b0;
              if (st_r == TWSI_TACK && rx_ack_flag_r) begin
                st_r <= TWSI_IDLE;
              end else begin
                hold_r <= 1'b1;
                st_r   <= TWSI_HOLD;
              end
            end
          end
          TWSI_RX: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_in};
              cnt_r   <= cnt_r + 4'h1;
            end
            if (scl_fall && cnt_r == TWSI_BITS_BYTE) begin
              data_r   <= shift_r;
              done_r   <= 1'b1;
              irq_r    <= 1'b1;
              sda_lo_r <= !tx_ack_ctrl_r;
              st_r     <= TWSI_RACK;
            end
          end
          TWSI_TX: begin
            if (scl_fall) begin
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == TWSI_BITS_BYTE - 4'h1) begin
                sda_lo_r <= 1'b0; // Release for the master ack
                done_r   <= 1'b1;
                irq_r    <= 1'b1;
                st_r     <= TWSI_TACK;
              end else begin
                shift_r  <= {shift_r[6:0], 1'b0};
                sda_lo_r <= !shift_r[6];
              end
            end
          end
        endcase
      end
    end
  end

  // Open-drain outputs: only ever pull low
  assign o_scl    = 1'b0;
  assign o_sda    = 1'b0;
  assign o_scl_oe = enabled && hold_r;
  assign o_sda_oe = enabled && sda_lo_r;
  assign o_rdata  = rdata_r;
  assign o_irq    = irq_r && i_irq_en;
endmodule : twsi_slave
`default_nettype wire

// ==== common/twsi_pkg.sv ====
// Purpose: Shared constants for the two-wire slave interface
// Assumes: 8-bit register port, byte-wide data
// Notes:   Offsets are register indices on the plain register port
`default_nettype none
package twsi_pkg;
  localparam int unsigned TWSI_AW = 2;
  localparam int unsigned TWSI_DW = 8;
  // Register offsets
  localparam logic [1:0] TWSI_OFS_CTRL0 = 2'h0;
  localparam logic [1:0] TWSI_OFS_STAT  = 2'h1;
  localparam logic [1:0] TWSI_OFS_ADDR  = 2'h2;
  localparam logic [1:0] TWSI_OFS_DATA  = 2'h3;
  // Control zero fields
  localparam int unsigned TWSI_B_EN     = 0;
  localparam int unsigned TWSI_B_MODE_L = 5;
  localparam logic [2:0]  TWSI_MODE_TWI = 3'h6;
  // Status/control fields
  localparam int unsigned TWSI_B_RX_ACK_FLAG = 0;
  localparam int unsigned TWSI_B_SRW  = 2;
  localparam int unsigned TWSI_B_TX_ACK_CTRL = 3;
  localparam int unsigned TWSI_B_TXM  = 4;
  localparam int unsigned TWSI_B_BB   = 5;
  localparam int unsigned TWSI_B_AM   = 6;
  localparam int unsigned TWSI_B_DONE = 7;
  // Reset values, then byte and ack bit counts
  localparam logic [7:0] TWSI_RST_CTRL0 = 8'h00;
  localparam logic [7:0] TWSI_RST_ADDR  = 8'h00;
  localparam logic [7:0] TWSI_RST_DATA  = 8'h00;
  localparam logic [3:0] TWSI_BITS_BYTE = 4'h8;
  localparam logic [3:0] TWSI_BIT_ACK   = 4'h9;
  typedef enum logic [2:0] {
    TWSI_IDLE, TWSI_ADDR, TWSI_AACK, TWSI_RX, TWSI_RACK, TWSI_TX, TWSI_TACK, TWSI_HOLD
  } twsi_state_t;
endpackage : twsi_pkg
`default_nettype wire

// ==== testbench/twsi_slave_sva.sv ====
// Purpose: Port checks for the two-wire slave
// Assumes: Bound to the slave from the bench top
// Notes:   Latency bounds cover up to two debounce clocks
`default_nettype none
module twsi_slave_sva #(
  parameter int unsigned DEBOUNCE = 0
) (
  // Clock, reset, register port
  input wire logic                         i_clk, i_rst, i_wr, i_rd, i_irq_en,
  input wire logic [twsi_pkg::TWSI_AW-1:0] i_addr,
  input wire logic [twsi_pkg::TWSI_DW-1:0] i_wdata, o_rdata,
  // Interrupt and pins
  input wire logic                         o_irq, i_scl, o_scl, o_scl_oe,
  input wire logic                         i_sda, o_sda, o_sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  import twsi_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Software touching the data or control register
  wire data_acc = (i_wr | i_rd) & (i_addr == TWSI_OFS_DATA);
  wire ctl_wr   = i_wr & (i_addr == TWSI_OFS_CTRL0);
  // Stretch in force, then freed shortly after the access
  sequence s_held;  o_scl_oe & data_acc; endsequence
  sequence s_freed; ##[1:4] !o_scl_oe; endsequence
  a_pins_low: assert property (!o_scl && !o_sda)
    else $error("pin data not low");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  a_irq_pulse: assert property (o_irq |=> !o_irq)
    else $error("interrupt longer than one cycle");
  a_irq_gated: assert property (!i_irq_en |-> !o_irq)
    else $error("interrupt while disabled");
  a_off_release: assert property (ctl_wr && !i_wdata[TWSI_B_EN] |-> ##[1:3]
    (!o_scl_oe && !o_sda_oe)) else $error("lines kept after disable");
  a_sda_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data moved while clock high");
  a_hold_keep: assert property (o_scl_oe && !data_acc && !ctl_wr |=> o_scl_oe)
    else $error("clock hold dropped early");
  a_hold_free: assert property (s_held |-> s_freed)
    else $error("clock hold not freed");
endmodule : twsi_slave_sva
`default_nettype wire

// ==== testbench/twsi_mst_model.sv ====
// Purpose: Behavioural bus master for the two lines
// Assumes: Lines are wired-and with pull-ups in the bench
// Notes:   80 ns bit clock; waits while the slave holds clock low
`default_nettype none
module twsi_mst_model (
  // Resolved line levels
  input  wire logic scl, sda,
  // Master pulls, one means released
  output logic      scl_m = 1'b1, sda_m = 1'b1
);
  timeunit 1ns;
  timeprecision 100ps;
  // Data falls while clock high
  task automatic start();
    #40 sda_m = 1'b0;
    #40 scl_m = 1'b0;
  endtask : start
  // Data rises while clock high; also ends an unacked call
  task automatic stop();
    #20 sda_m = 1'b0;
    #20 scl_m = 1'b1;
    wait (scl === 1'b1);
    #40 sda_m = 1'b1;
    #40;
  endtask : stop
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    logic [8:0] sh;
    sh = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      #20 sda_m = sh[i];
      #20 scl_m = 1'b1;
      wait (scl === 1'b1);
      #20;
      if (i > 0) rx[i-1] = sda;
      else ack_out = sda;
      #20 scl_m = 1'b0;
    end
    #10 sda_m = 1'b1;
  endtask : xfer
endmodule : twsi_mst_model
`default_nettype wire

// ==== testbench/tb_twsi_slave.sv ====
// Purpose: Register-driven test of the two-wire slave
// Assumes: Pull-ups on both lines, master model on far side
// Notes:   Debounce set to two clocks to stretch sync latency
`default_nettype none
module tb_twsi_slave;
  timeunit 1ns;
  timeprecision 100ps;
  import twsi_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_irq_en = 1'b0;
  logic [TWSI_AW-1:0] i_addr = '0;
  logic [7:0] i_wdata = '0, o_rdata, rx;
  logic o_irq, o_scl, o_scl_oe, o_sda, o_sda_oe, scl_m, sda_m, ak;
  int n_mismatch = 0, checked = 0;
  // Open-drain lines with pull-ups
  wire scl_w = scl_m & ~o_scl_oe;
  wire sda_w = sda_m & ~o_sda_oe;
  always #2 i_clk = ~i_clk;
  twsi_slave #(.DEBOUNCE(2)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_irq_en(i_irq_en),
    .o_irq(o_irq), .i_scl(scl_w), .o_scl(o_scl), .o_scl_oe(o_scl_oe), .i_sda(sda_w),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe));
  twsi_mst_model mst_u (.scl(scl_w), .sda(sda_w), .scl_m(scl_m), .sda_m(sda_m));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [TWSI_AW-1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  // Masked compare; data stands only in the cycle after the strobe
  task automatic rd(input logic [TWSI_AW-1:0] a, input logic [7:0] exp, input logic [7:0] msk);
    @(posedge i_clk);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata & msk, exp);
  endtask : rd
  // Wait for interrupt pulse or clock hold, bounded
  task automatic wait_ev(input bit hold);
    int k;
    k = 0;
    repeat (8) @(posedge i_clk);
    #1;
    while ((hold ? o_scl_oe : o_irq) !== 1'b1 && k < 3000) begin
      @(posedge i_clk);
      #1 k++;
    end
    chk({7'h0, hold ? o_scl_oe : o_irq}, 8'h01);
  endtask : wait_ev
  task automatic wrap_up();
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    #100us;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(TWSI_OFS_CTRL0, TWSI_RST_CTRL0, 8'hFF);
    rd(TWSI_OFS_STAT, 8'h00, 8'hFF);
    // Bit zero set on purpose: it must not take part in matching
    wr(TWSI_OFS_ADDR, 8'hA5);
    wr(TWSI_OFS_CTRL0, {TWSI_MODE_TWI, 5'h01});
    i_irq_en <= 1'b1;
    rd(TWSI_OFS_ADDR, 8'hA5, 8'hFF);
    // Foreign address: no ack, busy until stop
    mst_u.start();
    mst_u.xfer(8'h40, 1'b1, rx, ak);
    chk({7'h0, ak}, 8'h01);
    rd(TWSI_OFS_STAT, 8'h20, 8'h60);
    mst_u.stop();
    rd(TWSI_OFS_STAT, 8'h00, 8'h60);
    // Master writes; slave receives, last byte refused
    fork
      begin
        mst_u.start();
        mst_u.xfer(8'hA4, 1'b1, rx, ak);
        chk({7'h0, ak}, 8'h00);
        mst_u.xfer(8'h96, 1'b1, rx, ak);
        chk({7'h0, ak}, 8'h00);
        mst_u.xfer(8'h3C, 1'b1, rx, ak);
        chk({7'h0, ak}, 8'h01);
        mst_u.stop();
      end
      begin
        wait_ev(1'b0);
        rd(TWSI_OFS_STAT, 8'h60, 8'h64);
        wait_ev(1'b1);
        wr(TWSI_OFS_STAT, 8'h00);
        rd(TWSI_OFS_DATA, 8'h00, 8'h00);
        wait_ev(1'b0);
        rd(TWSI_OFS_STAT, 8'h80, 8'h80);
        wait_ev(1'b1);
        wr(TWSI_OFS_STAT, 8'h08);
        rd(TWSI_OFS_DATA, 8'h96, 8'hFF);
        wait_ev(1'b0);
        // Let the refused slot finish before freeing a possible hold
        repeat (30) @(posedge i_clk);
        rd(TWSI_OFS_DATA, 8'h3C, 8'hFF);
      end
    join
    // Master reads; slave transmits until refused
    fork
      begin
        mst_u.start();
        mst_u.xfer(8'hA5, 1'b1, rx, ak);
        chk({7'h0, ak}, 8'h00);
        mst_u.xfer(8'hFF, 1'b0, rx, ak);
        chk(rx, 8'hC3);
        mst_u.xfer(8'hFF, 1'b1, rx, ak);
        chk(rx, 8'h5A);
        mst_u.stop();
      end
      begin
        wait_ev(1'b0);
        rd(TWSI_OFS_STAT, 8'h64, 8'h64);
        wait_ev(1'b1);
        wr(TWSI_OFS_STAT, 8'h10);
        wr(TWSI_OFS_DATA, 8'hC3);
        wait_ev(1'b1);
        rd(TWSI_OFS_STAT, 8'h80, 8'h81);
        wr(TWSI_OFS_DATA, 8'h5A);
      end
    join
    rd(TWSI_OFS_STAT, 8'h01, 8'h21);
    wr(TWSI_OFS_CTRL0, 8'h00);
    rd(TWSI_OFS_CTRL0, 8'h00, 8'hFF);
    wrap_up();
  end
endmodule : tb_twsi_slave
bind twsi_slave twsi_slave_sva #(.DEBOUNCE(DEBOUNCE)) sva_u (.i_clk(i_clk), .i_rst(i_rst),
  .i_wr(i_wr), .i_rd(i_rd), .i_irq_en(i_irq_en), .i_addr(i_addr), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .o_irq(o_irq), .i_scl(i_scl), .o_scl(o_scl), .o_scl_oe(o_scl_oe),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe));
`default_nettype wire
